// File: rtl/ds3_perf_consts.vh
// Offsets, fields, reset values and timing counts for the performance block
`ifndef DS3_PERF_CONSTS_VH
`define DS3_PERF_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFF_MODE_CTRL 8'h02
`define OFF_DS2_FRAME_LOSS 8'h03
`define OFF_FAR_END_CNT 8'h04
`define OFF_CBIT_FRAME_CNT 8'h05
`define OFF_PBIT_CNT 8'h06

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define BIT_FORMAT_SELECT 0
`define RST_FORMAT_SELECT 1'b0
`define RST_COUNT 8'h00
`define COUNT_MAX 8'hff

// ----------------------------------------------------------------
// DS2 framing
// ----------------------------------------------------------------
`define DS2_FBIT_SPACING 49
`define DS2_HUNT_WIDTH 12
`define DS2_HUNT_PASSES 2'd3
`define DS2_CONFIRM_FBITS 24

`endif

// File: rtl/ds3_perf_counters.v
// DS3 receive performance counters and DS2 frame-loss monitor
`timescale 1ns/1ps
`include "ds3_perf_consts.vh"
// How it works
// - Status bits 6..0 show frame loss for DS2 tributaries 7..1.
// - Two errored framing bits among four consecutive declare frame loss.
// - Frame loss with AIS select 00 or 01 forces AIS on four DS1s.
// - Hunt finds alternating pattern: bit 49 positions later is opposite.
// - Hunt tracks twelve candidate bit positions at once.
// - After pattern found, 24 more framing bits confirm before alarm clears.
// - C-bit mode: count frames where C10, C11 or C12 is zero.
// - First counter sticks at 255 until read.
// - M13 mode: first counter counts F and M bit errors, freezes in OOF.
// - C-bit mode: second counter counts C-bit parity errors.
// - M13 mode: second counter counts received DS3 frames.
// - Third counter counts P-bit parity errors in both modes.
// - Event during read is held and applied after the read clears.
// - Only one held event per counter; extra ones are dropped.
// - All counters stop during DS3 loss of signal or out of frame.
// - Reading a counter clears it; each read consumes the count.
// - Format select one means M13 mode, zero means C-bit parity.
module ds3_perf_counters #(
    parameter FBIT_SPACING = `DS2_FBIT_SPACING,
    parameter CONFIRM_FBITS = `DS2_CONFIRM_FBITS
) (
    input wire clk_sys,
    input wire rst_b,
    input wire ce,
    input wire [7:0] addr,
    input wire rd_en,
    input wire wr_en,
    input wire [7:0] wdata,
    output reg [7:0] rdata,
    input wire [6:0] ds2_bit,
    input wire [6:0] ds2_bit_en,
    input wire tributary_ais_select_hi,
    input wire tributary_ais_select_lo,
    input wire ds3_frame_strobe,
    input wire c10_bit,
    input wire c11_bit,
    input wire c12_bit,
    input wire fm_bit_error,
    input wire cbit_parity_error,
    input wire pbit_parity_error,
    input wire ds3_los,
    input wire ds3_oof,
    output reg [6:0] ds2_frame_loss_flag,
    output reg [27:0] ds1_ais_insert,
    output reg ds3_format_select
);

    localparam [1:0] ST_IN_FRAME = 2'd0;
    localparam [1:0] ST_HUNT = 2'd1;
    localparam [1:0] ST_CONFIRM = 2'd2;
    // Integer forms first, then cut to the counter widths on purpose
    localparam integer LAST_PH_I = FBIT_SPACING - 1;
    localparam integer SPACING_I = FBIT_SPACING;
    localparam integer HUNT_W_I = `DS2_HUNT_WIDTH;
    localparam integer BASE_WRAP_I = FBIT_SPACING - `DS2_HUNT_WIDTH;
    localparam integer CONF_LAST_I = CONFIRM_FBITS - 1;
    localparam [5:0] LAST_PH = LAST_PH_I[5:0];
    localparam [5:0] SPACING = SPACING_I[5:0];
    localparam [5:0] HUNT_W = HUNT_W_I[5:0];
    localparam [5:0] BASE_WRAP = BASE_WRAP_I[5:0];
    localparam [4:0] CONF_LAST = CONF_LAST_I[4:0];

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    reg rst_meta_b_r;
    reg rst_sync_b_r;

    // Async assert, two-stage release
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_b_r <= 1'b0;
            rst_sync_b_r <= 1'b0;
        end else begin
            rst_meta_b_r <= 1'b1;
            rst_sync_b_r <= rst_meta_b_r;
        end
    end

    // Two or more ones among four history bits
    function two_of_four;
        input [3:0] h;
        begin
            two_of_four = (h[0] & h[1]) | (h[0] & h[2]) | (h[0] & h[3])
                | (h[1] & h[2]) | (h[1] & h[3]) | (h[2] & h[3]);
        end
    endfunction

    // Saturating increment, never wraps to zero
    function [7:0] sat_inc;
        input [7:0] v;
        begin
            sat_inc = (v == `COUNT_MAX) ? v : v + 8'h01;
        end
    endfunction

    // ------------------------------------------------------------
    // DS2 framers, one per tributary
    // ------------------------------------------------------------
    wire [6:0] oof_w;

    genvar k;
    generate
        for (k = 0; k < 7; k = k + 1) begin : g_ds2
            reg [1:0] st_r;
            reg [5:0] ph_r;
            reg [48:0] hist_r;
            reg [3:0] errh_r;
            reg exp_r;
            reg [5:0] base_r;
            reg [1:0] pass_r;
            reg [23:0] cand_r;
            reg [4:0] conf_r;
            reg oof_r;
            wire b = ds2_bit[k];
            wire [5:0] off = (ph_r >= base_r) ? ph_r - base_r
                : ph_r + SPACING - base_r;
            wire alt = b ^ hist_r[FBIT_SPACING-1];
            wire [1:0] cnt = cand_r[off*2 +: 2];
            wire ferr = b ^ exp_r;
            assign oof_w[k] = oof_r;

            // Bit-serial framer; idle between bit strobes
            always @(posedge clk_sys or negedge rst_sync_b_r) begin
                if (!rst_sync_b_r) begin
                    st_r <= ST_HUNT;
                    ph_r <= 6'h00;
                    hist_r <= 49'h0;
                    errh_r <= 4'h0;
                    exp_r <= 1'b0;
                    base_r <= 6'h00;
                    pass_r <= 2'h0;
                    cand_r <= 24'h0;
                    conf_r <= 5'h00;
                    oof_r <= 1'b1;
                end else if (ce && ds2_bit_en[k]) begin
                    hist_r <= {hist_r[47:0], b};
                    ph_r <= (ph_r == LAST_PH) ? 6'h00 : ph_r + 6'h01;
                    case (st_r)
                        ST_IN_FRAME: begin
                            if (ph_r == 6'h00) begin
                                exp_r <= ~exp_r;
                                errh_r <= {errh_r[2:0], ferr};
                                if (two_of_four({errh_r[2:0], ferr})) begin
                                    st_r <= ST_HUNT;
                                    oof_r <= 1'b1;
                                    cand_r <= 24'h0;
                                    pass_r <= 2'h0;
                                end
                            end
                        end
                        ST_HUNT: begin
                            // Twelve phases share one pass of the stream
                            if (off < HUNT_W) begin
                                if (alt && cnt == 2'd2) begin
                                    st_r <= ST_CONFIRM;
                                    ph_r <= 6'h01;
                                    exp_r <= ~b;
                                    conf_r <= 5'h00;
                                end else if (alt) begin
                                    cand_r[off*2 +: 2] <= cnt + 2'd1;
                                end else begin
                                    cand_r[off*2 +: 2] <= 2'd0;
                                end
                            end
                            // Give up on this window after a few frames
                            if (ph_r == LAST_PH) begin
                                pass_r <= pass_r + 2'h1;
                                if (pass_r == `DS2_HUNT_PASSES) begin
                                    cand_r <= 24'h0;
                                    base_r <= (base_r >= BASE_WRAP)
                                        ? base_r - BASE_WRAP : base_r + HUNT_W;
                                end
                            end
                        end
                        ST_CONFIRM: begin
                            if (ph_r == 6'h00) begin
                                exp_r <= ~exp_r;
                                if (ferr) begin
                                    st_r <= ST_HUNT;
                                    cand_r <= 24'h0;
                                    pass_r <= 2'h0;
                                end else if (conf_r == CONF_LAST) begin
                                    st_r <= ST_IN_FRAME;
                                    oof_r <= 1'b0;
                                    errh_r <= 4'h0;
                                end else begin
                                    conf_r <= conf_r + 5'h01;
                                end
                            end
                        end
                        default: st_r <= ST_HUNT;
                    endcase
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Alarm outputs and AIS insertion
    // ------------------------------------------------------------
    wire ais_enabled = ~tributary_ais_select_hi; // 00 or 01 selects AIS

    integer j;
    always @(posedge clk_sys or negedge rst_sync_b_r) begin
        if (!rst_sync_b_r) begin
            ds2_frame_loss_flag <= 7'h7f;
            ds1_ais_insert <= 28'h0;
        end else if (ce) begin
            ds2_frame_loss_flag <= oof_w;
            for (j = 0; j < 7; j = j + 1) begin
                ds1_ais_insert[j*4 +: 4] <= {4{oof_w[j] & ais_enabled}};
            end
        end
    end

    // ------------------------------------------------------------
    // Counter events
    // ------------------------------------------------------------
    wire inhibit = ds3_los | ds3_oof; // Also covers M13 freeze in OOF
    wire febe = ds3_frame_strobe & ~(c10_bit & c11_bit & c12_bit);
    wire [2:0] ev_raw;
    wire [2:0] ev;
    assign ev_raw[0] = ds3_format_select ? fm_bit_error : febe;
    assign ev_raw[1] = ds3_format_select ? ds3_frame_strobe
        : cbit_parity_error;
    assign ev_raw[2] = pbit_parity_error;
    assign ev = inhibit ? 3'b000 : ev_raw;

    // ------------------------------------------------------------
    // Host read cycle tracking
    // ------------------------------------------------------------
    reg rd_d_r;
    reg [7:0] rd_addr_r;
    wire rd_start = rd_en & ~rd_d_r;
    wire rd_end = rd_d_r & ~rd_en;

    // Address is held from the start of the cycle to its end
    always @(posedge clk_sys or negedge rst_sync_b_r) begin
        if (!rst_sync_b_r) begin
            rd_d_r <= 1'b0;
            rd_addr_r <= 8'h00;
        end else if (ce) begin
            rd_d_r <= rd_en;
            if (rd_start) begin
                rd_addr_r <= addr;
            end
        end
    end

    // ------------------------------------------------------------
    // Clear-on-read saturating counters
    // ------------------------------------------------------------
    wire [23:0] cnt_flat;

    genvar c;
    generate
        for (c = 0; c < 3; c = c + 1) begin : g_cnt
            localparam integer OFF_I = `OFF_FAR_END_CNT + c;
            localparam [7:0] OFF = OFF_I[7:0];
            reg [7:0] count_r;
            reg pend_r;
            wire busy = (rd_en | rd_d_r) &&
                ((rd_start ? addr : rd_addr_r) == OFF);
            assign cnt_flat[c*8 +: 8] = count_r;

            // Held event lands as the first count after the clear
            always @(posedge clk_sys or negedge rst_sync_b_r) begin
                if (!rst_sync_b_r) begin
                    count_r <= `RST_COUNT;
                    pend_r <= 1'b0;
                end else if (ce) begin
                    if (rd_end && rd_addr_r == OFF) begin
                        count_r <= `RST_COUNT;
                        pend_r <= pend_r | ev[c];
                    end else if (busy) begin
                        if (ev[c]) begin
                            pend_r <= 1'b1;
                        end
                    end else if (pend_r) begin
                        count_r <= sat_inc(count_r);
                        pend_r <= ev[c];
                    end else if (ev[c]) begin
                        count_r <= sat_inc(count_r);
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Register writes and read data
    // ------------------------------------------------------------
    // Mode register write
    always @(posedge clk_sys or negedge rst_sync_b_r) begin
        if (!rst_sync_b_r) begin
            ds3_format_select <= `RST_FORMAT_SELECT;
        end else if (ce && wr_en && addr == `OFF_MODE_CTRL) begin
            ds3_format_select <= wdata[`BIT_FORMAT_SELECT];
        end
    end

    // Read data is captured at cycle start, before any clear
    always @(posedge clk_sys or negedge rst_sync_b_r) begin
        if (!rst_sync_b_r) begin
            rdata <= 8'h00;
        end else if (ce && rd_start) begin
            if (addr == `OFF_MODE_CTRL) begin
                rdata <= {7'h00, ds3_format_select};
            end else if (addr == `OFF_DS2_FRAME_LOSS) begin
                rdata <= {1'b0, ds2_frame_loss_flag};
            end else if (addr == `OFF_FAR_END_CNT) begin
                rdata <= cnt_flat[7:0];
            end else if (addr == `OFF_CBIT_FRAME_CNT) begin
                rdata <= cnt_flat[15:8];
            end else if (addr == `OFF_PBIT_CNT) begin
                rdata <= cnt_flat[23:16];
            end else begin
                rdata <= 8'h00;
            end
        end
    end

endmodule // ds3_perf_counters

// File: verif/ds3_perf_chk_sva.sv
// Port-level checker for the DS3 performance block
`timescale 1ns/1ps
module ds3_perf_chk (
    input wire clk_sys,
    input wire rst_b,
    input wire ce,
    input wire [7:0] addr,
    input wire rd_en,
    input wire wr_en,
    input wire [7:0] wdata,
    input wire [7:0] rdata,
    input wire [6:0] ds2_bit_en,
    input wire tributary_ais_select_hi,
    input wire ds3_frame_strobe,
    input wire fm_bit_error,
    input wire cbit_parity_error,
    input wire pbit_parity_error,
    input wire ds3_los,
    input wire ds3_oof,
    input wire [6:0] ds2_frame_loss_flag,
    input wire [27:0] ds1_ais_insert,
    input wire ds3_format_select
);
    reg [2:0] up_r;
    reg rd_q_r, quiet_r, wv_r;
    reg [7:0] prev_r;
    wire live = up_r[2];
    wire start = ce && rd_en && !rd_q_r;
    wire mwr = ce && wr_en && addr == 8'h02;
    wire ev = ce && !ds3_los && !ds3_oof && (ds3_frame_strobe ||
        fm_bit_error || cbit_parity_error || pbit_parity_error);
    // Expected AIS map, a tributary in loss blanks its four DS1s
    function [27:0] ais_of(input [6:0] f, input hi);
        integer k;
        for (k = 0; k < 7; k = k + 1)
            ais_of[4*k+:4] = {4{f[k] & !hi}};
    endfunction
    // Skip the internal reset synchroniser; track reads and quiet spans
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            up_r <= 3'h0;
            rd_q_r <= 1'b0;
            quiet_r <= 1'b0;
            wv_r <= 1'b0;
            prev_r <= 8'h00;
        end else begin
            up_r <= live ? up_r : up_r + 3'h1;
            rd_q_r <= ce ? rd_en : rd_q_r;
            prev_r <= start ? addr : prev_r;
            wv_r <= mwr ? wdata[0] : wv_r;
            quiet_r <= !ev && (start || quiet_r); // Held events count too
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    a_status_read: assert property (live && start && addr == 8'h03
        |=> rdata == {1'b0, $past(ds2_frame_loss_flag)})
        else $error("status read differs from flags");
    a_rdata_stands: assert property (live && !start |=> $stable(rdata))
        else $error("read data changed without a read");
    a_second_read: assert property (live && start && addr == prev_r &&
        quiet_r && addr >= 8'h04 && addr <= 8'h06 |=> rdata == 8'h00)
        else $error("counter not cleared by previous read");
    a_mode_write: assert property (live && mwr ##1 !wr_en [*2]
        |-> ds3_format_select == wv_r)
        else $error("format select does not follow write");
    a_mode_hold: assert property ((live && !wr_en) [*3]
        |=> $stable(ds3_format_select))
        else $error("format select changed without write");
    a_ais_follow: assert property (live && ce |=> ds1_ais_insert ==
        ais_of(ds2_frame_loss_flag, $past(tributary_ais_select_hi)))
        else $error("AIS map does not follow flags");
    a_ais_off_sel: assert property ((live && tributary_ais_select_hi) [*2]
        |-> ds1_ais_insert == 28'h0000000)
        else $error("AIS inserted while select disables it");
    a_flag_quiet: assert property ((live && !(|ds2_bit_en)) [*3]
        |=> $stable(ds2_frame_loss_flag))
        else $error("flags moved with no DS2 bits");
endmodule // ds3_perf_chk

bind ds3_perf_counters ds3_perf_chk u_chk (.clk_sys, .rst_b, .ce, .addr,
    .rd_en, .wr_en, .wdata, .rdata, .ds2_bit_en, .tributary_ais_select_hi,
    .ds3_frame_strobe, .fm_bit_error, .cbit_parity_error,
    .pbit_parity_error, .ds3_los, .ds3_oof, .ds2_frame_loss_flag,
    .ds1_ais_insert, .ds3_format_select);

// File: verif/ds3_host_model.sv
// Host processor model driving the register bus
`timescale 1ns/1ps
module ds3_host_model (
    input wire clk_sys,
    input wire [7:0] rdata,
    output reg ce = 1'b1,
    output reg [7:0] addr = 8'h00,
    output reg rd_en = 1'b0,
    output reg wr_en = 1'b0,
    output reg [7:0] wdata = 8'h00
);
    // Read held for hold cycles; the low cycle after it lets the clear land
    task rd(input [7:0] a, input int hold, output [7:0] d);
        int i;
        @(negedge clk_sys);
        addr = a;
        rd_en = 1'b1;
        for (i = 0; i < hold; i++)
            @(negedge clk_sys);
        d = rdata;
        rd_en = 1'b0;
        @(negedge clk_sys);
        addr = ~a; // Idle address keeps moving, not a stale copy
    endtask
    // Single-cycle write
    task wr(input [7:0] a, input [7:0] v);
        @(negedge clk_sys);
        addr = a;
        wdata = v;
        wr_en = 1'b1;
        @(negedge clk_sys);
        wr_en = 1'b0;
        wdata = ~v;
    endtask
endmodule // ds3_host_model

// File: verif/ds3_perf_counters_ds2_oof_test.sv
// Self-checking bench for the DS3 performance block
`timescale 1ns/1ps
module ds3_perf_counters_ds2_oof_test;
    typedef struct {logic m; logic [2:0] cb; int nf, nm, nc, np;
        logic [7:0] e0, e1, e2;} row_t;
    row_t rows [6];
    reg clk_sys = 1'b0, rst_b = 1'b0, run2 = 1'b0, fb = 1'b0;
    wire ce, rd_en, wr_en, ds3_format_select;
    wire [7:0] addr, wdata, rdata;
    reg [6:0] ds2_bit = 7'h00, ds2_bit_en = 7'h00;
    reg tributary_ais_select_hi = 1'b0, tributary_ais_select_lo = 1'b0;
    reg ds3_frame_strobe = 1'b0, c10_bit = 1'b1, c11_bit = 1'b1;
    reg c12_bit = 1'b1, fm_bit_error = 1'b0, cbit_parity_error = 1'b0;
    reg pbit_parity_error = 1'b0, ds3_los = 1'b0, ds3_oof = 1'b0;
    wire [6:0] ds2_frame_loss_flag;
    wire [27:0] ds1_ais_insert;
    int pos = 0, n_bad = 0, n_mismatch = 0, n_checks = 0, i;
    logic [7:0] d;
    always #12.5 clk_sys = ~clk_sys;
    ds3_perf_counters #(.CONFIRM_FBITS(4)) u_dut (.clk_sys, .rst_b, .ce,
        .addr, .rd_en, .wr_en, .wdata, .rdata, .ds2_bit, .ds2_bit_en,
        .tributary_ais_select_hi, .tributary_ais_select_lo,
        .ds3_frame_strobe, .c10_bit, .c11_bit, .c12_bit, .fm_bit_error,
        .cbit_parity_error, .pbit_parity_error, .ds3_los, .ds3_oof,
        .ds2_frame_loss_flag, .ds1_ais_insert, .ds3_format_select);
    ds3_host_model u_host (.clk_sys, .rdata, .ce, .addr, .rd_en, .wr_en,
        .wdata);
    // DS2 streams: alternating framing bit every 49, ones elsewhere
    always @(negedge clk_sys) begin
        ds2_bit_en <= {7{run2}};
        pos <= !run2 ? pos : (pos == 48) ? 0 : pos + 1;
        if (!run2 || pos != 0)
            ds2_bit <= run2 ? 7'h7f : ~ds2_bit;
        else begin
            ds2_bit <= {7{fb}} ^ ((n_bad > 0) ? 7'h04 : 7'h00);
            fb <= ~fb;
            n_bad <= (n_bad > 0) ? n_bad - 1 : 0;
        end
    end
    task check(string w, input [27:0] s, input [27:0] e);
        n_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", w, e, s);
        end
    endtask
    task rc(string w, input [7:0] a, input [7:0] e);
        u_host.rd(a, 1, d);
        check(w, d, e);
    endtask
    // Pulse each event line for its row count, one per cycle
    task events(input row_t r);
        for (int k = 0; k <= 300; k++) begin
            @(negedge clk_sys);
            ds3_frame_strobe = k < r.nf;
            {c12_bit, c11_bit, c10_bit} = (k < r.nf) ? r.cb : ~r.cb;
            fm_bit_error = k < r.nm;
            cbit_parity_error = k < r.nc;
            pbit_parity_error = k < r.np;
        end
    endtask
    task wait_flags(input [6:0] v);
        for (int k = 0; k < 6000 && ds2_frame_loss_flag !== v; k++)
            @(negedge clk_sys);
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #600000; // About 24000 cycles, well past the expected run
        n_mismatch++;
        end_of_test;
    end
    initial begin
        rows = '{'{0, 3'b110, 5, 3, 4, 2, 8'h05, 8'h04, 8'h02},
            '{0, 3'b111, 6, 2, 1, 3, 8'h00, 8'h01, 8'h03},
            '{0, 3'b011, 2, 0, 0, 0, 8'h02, 8'h00, 8'h00},
            '{0, 3'b101, 300, 0, 300, 300, 8'hff, 8'hff, 8'hff},
            '{1, 3'b000, 7, 3, 5, 1, 8'h03, 8'h07, 8'h01},
            '{1, 3'b111, 260, 270, 2, 0, 8'hff, 8'hff, 8'h00}};
        repeat (2) @(negedge clk_sys);
        check("flags", ds2_frame_loss_flag, 7'h7f);
        check("fmt", ds3_format_select, 1'b0);
        rst_b = 1'b1;
        repeat (6) @(negedge clk_sys);
        rc("status", 8'h03, 8'h7f);
        rc("unmapped", 8'h01, 8'h00);
        rc("pcnt", 8'h06, 8'h00);
        rc("pcnt", 8'h06, 8'h00);
        for (i = 0; i < 6; i++) begin
            u_host.wr(8'h02, {7'h00, rows[i].m});
            events(rows[i]);
            check("fmt", ds3_format_select, rows[i].m);
            rc("cnt0", 8'h04, rows[i].e0);
            rc("cnt1", 8'h05, rows[i].e1);
            rc("cnt2", 8'h06, rows[i].e2);
        end
        // Loss of signal, then out of frame: nothing may count
        for (i = 0; i < 2; i++) begin
            {ds3_los, ds3_oof} = i ? 2'b01 : 2'b10;
            events(rows[4]);
            {ds3_los, ds3_oof} = 2'b00;
            for (int a = 4; a < 7; a++)
                rc("frozen", a[7:0], 8'h00);
        end
        // Two errors during a long read: one held, applied after clear
        fork
            u_host.rd(8'h04, 3, d);
            begin
                repeat (2) @(negedge clk_sys);
                fm_bit_error = 1'b1;
                repeat (2) @(negedge clk_sys);
                fm_bit_error = 1'b0;
            end
        join
        check("collide", d, 8'h00);
        rc("held", 8'h04, 8'h01);
        // Clock enable low: P-bit errors must not reach the counter
        u_host.ce = 1'b0;
        pbit_parity_error = 1'b1;
        repeat (4) @(negedge clk_sys);
        pbit_parity_error = 1'b0;
        u_host.ce = 1'b1;
        rc("ce_hold", 8'h06, 8'h00);
        // DS2 acquisition, single error tolerated, double error declares
        run2 = 1'b1;
        wait_flags(7'h00);
        check("flags", ds2_frame_loss_flag, 7'h00);
        @(posedge clk_sys) n_bad = 1;
        repeat (392) @(negedge clk_sys);
        check("flags", ds2_frame_loss_flag, 7'h00);
        @(posedge clk_sys) n_bad = 2;
        repeat (147) @(negedge clk_sys);
        check("flags", ds2_frame_loss_flag, 7'h04);
        check("ais", ds1_ais_insert, 28'h0000f00);
        tributary_ais_select_hi = 1'b1;
        repeat (2) @(negedge clk_sys);
        check("ais", ds1_ais_insert, 28'h0000000);
        {tributary_ais_select_hi, tributary_ais_select_lo} = 2'b01;
        repeat (2) @(negedge clk_sys);
        check("ais", ds1_ais_insert, 28'h0000f00);
        rc("status", 8'h03, 8'h04);
        wait_flags(7'h00);
        check("flags", ds2_frame_loss_flag, 7'h00);
        run2 = 1'b0;
        end_of_test;
    end
endmodule // ds3_perf_counters_ds2_oof_test
